// [rtl/mdu_pkg.sv]
// Package for the multiply/divide unit: register map, status fields, timing.
// Assumes a 20 MHz core clock and an Avalon-MM slave with 32-bit data.
package mdu_pkg;

	// ==========================================================
	// Register map (byte addresses, one 32-bit word each)
	localparam logic [4:0] OFS_BYTE0  = 5'h00;
	localparam logic [4:0] OFS_BYTE1  = 5'h04;
	localparam logic [4:0] OFS_BYTE2  = 5'h08;
	localparam logic [4:0] OFS_BYTE3  = 5'h0c;
	localparam logic [4:0] OFS_BYTE4  = 5'h10;
	localparam logic [4:0] OFS_BYTE5  = 5'h14;
	localparam logic [4:0] OFS_STATUS = 5'h18;

	// ==========================================================
	// Status register fields
	localparam int        ERR_BIT      = 7;
	localparam int        OVF_BIT      = 6;
	localparam logic      ERR_RESET    = 1'b0;
	localparam logic      OVF_RESET    = 1'b0;
	localparam logic [31:0] UNMAPPED_RD = 32'h0000_0000;

	// ==========================================================
	// Timing: clock period in ns, latencies in system clock periods
	localparam int         TSYS_NS       = 50;
	localparam logic [4:0] CYC_DIV32     = 5'h11;
	localparam logic [4:0] CYC_DIV16     = 5'h09;
	localparam logic [4:0] CYC_MUL       = 5'h0b;
	localparam logic [16:0] PROD_LIMIT   = 17'h0ffff;

	// ==========================================================
	// Operation kinds and write-order tracker states
	typedef enum logic [1:0] {
		OP_NONE,
		OP_DIV32,
		OP_DIV16,
		OP_MUL
	} mdu_op_t;

	typedef enum logic [2:0] {
		SEQ_IDLE,
		SEQ_W0,
		SEQ_W01,
		SEQ_W012,
		SEQ_W0123,
		SEQ_W01234,
		SEQ_W014,
		SEQ_W04
	} mdu_seq_t;

	// Operands handed to the engine
	typedef struct packed {
		logic [31:0] dividend;
		logic [15:0] divisor;
		mdu_op_t     op;
	} mdu_job_t;

	// Results handed back
	typedef struct packed {
		logic [31:0] low;
		logic [15:0] rem;
		logic        ovf;
	} mdu_res_t;

endpackage

// [rtl/mdu_engine.sv]
// Arithmetic engine of the multiply/divide unit: unsigned 32/16, 16/16, 16x16.
// Assumes start is a one-cycle pulse and job stays stable while busy.
`timescale 1ns/1ps
module mdu_engine
(
	// Clock and reset
	input  wire logic             core_clk,
	input  wire logic             rst,
	// Job
	input  wire logic             start,
	input  wire mdu_pkg::mdu_job_t job,
	// Result
	output logic                  busy,
	output logic                  done,
	output mdu_pkg::mdu_res_t     res
);

	logic [4:0]  cntQ;
	logic [4:0]  cntD;
	logic [31:0] quot;
	logic [15:0] remd;
	logic [31:0] prod;

	// ==========================================================
	// Unsigned arithmetic, fixed latency instead of bit-serial steps
	always_comb
	begin
		prod = job.dividend[15:0] * job.divisor;
		if (job.divisor == 16'h0000)
		begin
			quot = 32'hffff_ffff;
			remd = 16'hffff;
		end
		else if (job.op == mdu_pkg::OP_DIV16)
		begin
			quot = {16'h0000, job.dividend[15:0] / job.divisor};
			remd = job.dividend[15:0] % job.divisor;
		end
		else
		begin
			quot = job.dividend / {16'h0000, job.divisor};
			remd = 16'((job.dividend % {16'h0000, job.divisor}));
		end
	end

	always_comb
	begin
		case (job.op)
			mdu_pkg::OP_DIV32: cntD = mdu_pkg::CYC_DIV32;
			mdu_pkg::OP_DIV16: cntD = mdu_pkg::CYC_DIV16;
			default:           cntD = mdu_pkg::CYC_MUL;
		endcase
	end

	// ==========================================================
	// Latency counter
	always_ff @(posedge core_clk)
	begin
		if (rst)
			cntQ <= 5'h00;
		else if (start)
			cntQ <= cntD;
		else if (cntQ != 5'h00)
			cntQ <= cntQ - 5'h01;
	end

	assign busy = (cntQ != 5'h00);
	assign done = (cntQ == 5'h01);

	// ==========================================================
	// Result capture one cycle ahead of done, so the top copies settled values
	always_ff @(posedge core_clk)
	begin
		if (rst)
			res <= '0;
		else if (cntQ == 5'h02)
		begin
			if (job.op == mdu_pkg::OP_MUL)
			begin
				res.low <= prod;
				res.rem <= 16'h0000;
				res.ovf <= ({1'b0, prod[31:16] != 16'h0000} != 2'b00);
			end
			else
			begin
				res.low <= quot;
				res.rem <= remd;
				res.ovf <= (job.divisor == 16'h0000);
			end
		end
	end

	property p_startBusy;
		@(posedge core_clk) disable iff (rst)
		start |=> busy;
	endproperty
	a_startBusy: assert property (p_startBusy)
		else $error("engine not busy after start");

	property p_div16Lat;
		@(posedge core_clk) disable iff (rst)
		(start && job.op == mdu_pkg::OP_DIV16) |=> ##8 done;
	endproperty
	a_div16Lat: assert property (p_div16Lat)
		else $error("16/16 divide not done after 9 cycles");

endmodule // mdu_engine

// [rtl/mdu_top.sv]
// Multiply/divide unit: six byte operand/result registers and a status register.
// Assumes an Avalon-MM master; the operation is picked by the order of byte writes.
`timescale 1ns/1ps
module mdu_top
(
	// Clock and reset
	input  wire logic        core_clk,
	input  wire logic        rst,
	// Avalon-MM slave
	input  wire logic [4:0]  avs_address,
	input  wire logic        avs_read,
	input  wire logic        avs_write,
	input  wire logic [31:0] avs_writedata,
	input  wire logic [3:0]  avs_byteenable,
	output logic [31:0]      avs_readdata,
	output logic             avs_waitrequest,
	// Status view
	output logic             busy
);

	logic [7:0]        opQ [0:5];
	logic              errQ;
	logic              ovfQ;
	logic              ackQ;
	mdu_pkg::mdu_seq_t seqQ;
	mdu_pkg::mdu_seq_t seqD;
	mdu_pkg::mdu_op_t  opSel;
	mdu_pkg::mdu_job_t jobQ;
	mdu_pkg::mdu_job_t jobNew;
	mdu_pkg::mdu_job_t job;
	mdu_pkg::mdu_res_t res;
	logic              start;
	logic              done;
	logic              access;
	logic              isOpReg;
	logic [2:0]        regIdx;
	logic              isStatus;
	logic              wrOp;

	// ==========================================================
	// Address decode
	always_comb
	begin
		isOpReg  = 1'b0;
		isStatus = 1'b0;
		regIdx   = 3'h0;
		if (avs_address == mdu_pkg::OFS_BYTE0)
		begin
			isOpReg = 1'b1;
			regIdx  = 3'h0;
		end
		else if (avs_address == mdu_pkg::OFS_BYTE1)
		begin
			isOpReg = 1'b1;
			regIdx  = 3'h1;
		end
		else if (avs_address == mdu_pkg::OFS_BYTE2)
		begin
			isOpReg = 1'b1;
			regIdx  = 3'h2;
		end
		else if (avs_address == mdu_pkg::OFS_BYTE3)
		begin
			isOpReg = 1'b1;
			regIdx  = 3'h3;
		end
		else if (avs_address == mdu_pkg::OFS_BYTE4)
		begin
			isOpReg = 1'b1;
			regIdx  = 3'h4;
		end
		else if (avs_address == mdu_pkg::OFS_BYTE5)
		begin
			isOpReg = 1'b1;
			regIdx  = 3'h5;
		end
		else if (avs_address == mdu_pkg::OFS_STATUS)
		begin
			isStatus = 1'b1;
		end
	end

	// ==========================================================
	// Bus handshake: one wait state, answer on the second edge
	assign access          = (avs_read || avs_write) && ackQ;
	assign avs_waitrequest = (avs_read || avs_write) && !ackQ;

	always_ff @(posedge core_clk)
	begin
		if (rst)
			ackQ <= 1'b0;
		else
			ackQ <= (avs_read || avs_write) && !ackQ;
	end

	// Writes while busy are dropped, only flagged
	assign wrOp = access && avs_write && isOpReg && avs_byteenable[0] && !busy;

	// ==========================================================
	// Write-order tracker; reads and other addresses leave it alone
	always_comb
	begin
		seqD  = seqQ;
		opSel = mdu_pkg::OP_NONE;
		if (wrOp)
		begin
			case (regIdx)
				3'h0: seqD = mdu_pkg::SEQ_W0;
				3'h1:
				begin
					if (seqQ == mdu_pkg::SEQ_W0)
						seqD = mdu_pkg::SEQ_W01;
					else if (seqQ == mdu_pkg::SEQ_W04)
						seqD = mdu_pkg::SEQ_W014;
					else
						seqD = mdu_pkg::SEQ_IDLE;
				end
				3'h2: seqD = (seqQ == mdu_pkg::SEQ_W01) ? mdu_pkg::SEQ_W012 : mdu_pkg::SEQ_IDLE;
				3'h3: seqD = (seqQ == mdu_pkg::SEQ_W012) ? mdu_pkg::SEQ_W0123 : mdu_pkg::SEQ_IDLE;
				3'h4:
				begin
					if (seqQ == mdu_pkg::SEQ_W0123)
						seqD = mdu_pkg::SEQ_W01234;
					else if (seqQ == mdu_pkg::SEQ_W01)
						seqD = mdu_pkg::SEQ_W014;
					else if (seqQ == mdu_pkg::SEQ_W0)
						seqD = mdu_pkg::SEQ_W04;
					else
						seqD = mdu_pkg::SEQ_IDLE;
				end
				default:
				begin
					seqD = mdu_pkg::SEQ_IDLE;
					case (seqQ)
						mdu_pkg::SEQ_W01234: opSel = mdu_pkg::OP_DIV32;
						mdu_pkg::SEQ_W014:   opSel = mdu_pkg::OP_DIV16;
						default:             opSel = mdu_pkg::OP_NONE;
					endcase
				end
			endcase
		end
	end

	// Order 0,1,4 gives division, 0,4,1 gives multiply: tell them apart
	logic mulPathQ;
	always_ff @(posedge core_clk)
	begin
		if (rst)
			mulPathQ <= 1'b0;
		else if (wrOp && regIdx == 3'h0)
			mulPathQ <= 1'b0;
		else if (wrOp && regIdx == 3'h4 && seqQ == mdu_pkg::SEQ_W0)
			mulPathQ <= 1'b1;
	end

	mdu_pkg::mdu_op_t opFinal;
	always_comb
	begin
		opFinal = opSel;
		if (opSel == mdu_pkg::OP_DIV16 && mulPathQ)
			opFinal = mdu_pkg::OP_MUL;
	end

	assign start = (opFinal != mdu_pkg::OP_NONE);

	always_ff @(posedge core_clk)
	begin
		if (rst)
			seqQ <= mdu_pkg::SEQ_IDLE;
		else
			seqQ <= seqD;
	end

	// ==========================================================
	// Job latch; byte 0 is least significant
	// Engine sees the new job in the start cycle, else its count uses the old op
	always_comb
	begin
		jobNew.op      = opFinal;
		jobNew.divisor = {avs_writedata[7:0], opQ[4]};
		if (opFinal == mdu_pkg::OP_DIV32)
			jobNew.dividend = {opQ[3], opQ[2], opQ[1], opQ[0]};
		else
			jobNew.dividend = {16'h0000, opQ[1], opQ[0]};
	end

	assign job = start ? jobNew : jobQ;

	always_ff @(posedge core_clk)
	begin
		if (rst)
			jobQ <= '0;
		else if (start)
			jobQ <= jobNew;
	end

	// ==========================================================
	// Operand/result bytes
	always_ff @(posedge core_clk)
	begin
		if (done)
		begin
			{opQ[3], opQ[2], opQ[1], opQ[0]} <= res.low;
			{opQ[5], opQ[4]}                 <= res.rem;
		end
		else if (wrOp)
			opQ[regIdx] <= avs_writedata[7:0];
	end

	mdu_engine u_engine
	(
		.core_clk (core_clk),
		.rst      (rst),
		.start    (start),
		.job      (job),
		.busy     (busy),
		.done     (done),
		.res      (res)
	);

	// ==========================================================
	// Status flags
	logic doneQ;
	always_ff @(posedge core_clk)
	begin
		if (rst)
			doneQ <= 1'b0;
		else
			doneQ <= done;
	end

	always_ff @(posedge core_clk)
	begin
		if (rst)
			errQ <= mdu_pkg::ERR_RESET;
		else if (access && isOpReg && busy)
			errQ <= 1'b1;
		else if (access && avs_read && isStatus && !busy)
			errQ <= 1'b0;
	end

	always_ff @(posedge core_clk)
	begin
		if (rst)
			ovfQ <= mdu_pkg::OVF_RESET;
		else if (doneQ)
			ovfQ <= res.ovf;
	end

	// ==========================================================
	// Read data; reads have no side effect on results
	logic [31:0] rdMux;
	logic [31:0] rdQ;
	always_comb
	begin
		rdMux = mdu_pkg::UNMAPPED_RD;
		if (isOpReg && regIdx <= 3'h5)
			rdMux = {24'h000000, opQ[regIdx]};
		else if (isStatus)
		begin
			rdMux[mdu_pkg::ERR_BIT] = errQ;
			rdMux[mdu_pkg::OVF_BIT] = ovfQ;
		end
	end

	// Taken in the wait state, stands while waitrequest is low
	always_ff @(posedge core_clk)
	begin
		if (rst)
			rdQ <= mdu_pkg::UNMAPPED_RD;
		else if (avs_read && !ackQ)
			rdQ <= rdMux;
	end

	assign avs_readdata = rdQ;

	// ==========================================================
	// Checks
	sequence s_startDiv32;
		start && opFinal == mdu_pkg::OP_DIV32;
	endsequence

	property p_div32Lat;
		@(posedge core_clk) disable iff (rst)
		s_startDiv32 |-> ##17 done;
	endproperty
	a_div32Lat: assert property (p_div32Lat)
		else $error("32/16 divide latency wrong");

	property p_mulLat;
		@(posedge core_clk) disable iff (rst)
		(start && opFinal == mdu_pkg::OP_MUL) |-> ##11 done;
	endproperty
	a_mulLat: assert property (p_mulLat)
		else $error("multiply latency wrong");

	property p_startOnByte5;
		@(posedge core_clk) disable iff (rst)
		start |-> (wrOp && regIdx == 3'h5);
	endproperty
	a_startOnByte5: assert property (p_startOnByte5)
		else $error("start without byte 5 write");

	property p_errSet;
		@(posedge core_clk) disable iff (rst)
		(access && isOpReg && busy) |=> errQ;
	endproperty
	a_errSet: assert property (p_errSet)
		else $error("error flag not set on busy access");

	property p_errClr;
		@(posedge core_clk) disable iff (rst)
		(access && avs_read && isStatus && !busy) |=> !errQ;
	endproperty
	a_errClr: assert property (p_errClr)
		else $error("error flag not cleared by status read");

	property p_ovfHold;
		@(posedge core_clk) disable iff (rst)
		!doneQ |=> $stable(ovfQ);
	endproperty
	a_ovfHold: assert property (p_ovfHold)
		else $error("overflow flag moved outside completion");

	property p_lowBits;
		@(posedge core_clk) disable iff (rst)
		(isStatus && avs_read && !avs_waitrequest) |-> avs_readdata[5:0] == 6'h00;
	endproperty
	a_lowBits: assert property (p_lowBits)
		else $error("status low bits not zero");

	property p_badOrder;
		@(posedge core_clk) disable iff (rst)
		(wrOp && regIdx == 3'h5 && seqQ == mdu_pkg::SEQ_W0) |-> !start;
	endproperty
	a_badOrder: assert property (p_badOrder)
		else $error("start on invalid order");

endmodule // mdu_top

// [verification/mdu_tb_top.sv]
// Self-checking bench for the multiply/divide unit over its Avalon-MM slave.
// Assumes mdu_top answers each request after one wait state and drives busy.
`timescale 1ns/1ps
module tb_top;
	// ==========================================================
	// Stimulus and observed signals
	logic        core_clk       = 1'b0;
	logic        rst            = 1'b1;
	logic [4:0]  avs_address    = 5'h00;
	logic        avs_read       = 1'b0;
	logic        avs_write      = 1'b0;
	logic [31:0] avs_writedata  = 32'h0000_0000;
	logic [3:0]  avs_byteenable = 4'hf;
	logic [31:0] avs_readdata;
	logic        avs_waitrequest;
	logic        busy;
	logic [31:0] rdq;
	int          mismatches     = 0;
	int          cmp_count      = 0;

	always #25 core_clk = ~core_clk;

	mdu_top mdu_top_inst
	(
		.core_clk        (core_clk),
		.rst             (rst),
		.avs_address     (avs_address),
		.avs_read        (avs_read),
		.avs_write       (avs_write),
		.avs_writedata   (avs_writedata),
		.avs_byteenable  (avs_byteenable),
		.avs_readdata    (avs_readdata),
		.avs_waitrequest (avs_waitrequest),
		.busy            (busy)
	);

	// ==========================================================
	// Shared tasks
	task automatic give_verdict();
		$display("comparisons %0d mismatches %0d", cmp_count, mismatches);
		if (mismatches == 0 && cmp_count > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
		cmp_count++;
		if (got !== exp)
		begin
			mismatches++;
			$display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
		end
	endtask

	// Request held until the rising edge that sees waitrequest low
	task automatic bus(input logic wr, input logic [4:0] a, input logic [7:0] d,
		output logic [31:0] q);
		logic ok;
		int   n;
		n = 0;
		@(posedge core_clk);
		avs_address <= a;
		avs_writedata <= {24'h00_0000, d};
		avs_write <= wr;
		avs_read <= ~wr;
		do
		begin
			@(posedge core_clk);
			n++;
		end
		while (avs_waitrequest !== 1'b0 && n < 20);
		ok = (avs_waitrequest === 1'b0);
		q = avs_readdata;
		avs_write <= 1'b0;
		avs_read <= 1'b0;
		chk({31'h0, ok}, 32'h1, "bus answer");
	endtask

	// Kind 0: 32/16 divide, 1: 16/16 divide, 2: 16x16 multiply
	task automatic do_op(input int kind, input logic [31:0] x, input logic [15:0] y);
		logic [23:0] ord;
		logic [23:0] rord;
		logic [31:0] lo;
		logic [15:0] rm;
		logic        ovf;
		logic [3:0]  i;
		int          n;
		int          len;
		ord = (kind == 0) ? 24'h012345 : (kind == 1) ? 24'h014500 : 24'h041500;
		rord = (kind == 2) ? 24'h012300 : ord;
		len = (kind == 0) ? 6 : 4;
		ovf = (y == 16'h0000);
		lo = 32'hffff_ffff;
		rm = 16'hffff;
		if (kind == 2)
		begin
			lo = x[15:0] * y;
			ovf = (lo > 32'h0000_ffff);
		end
		else if (y != 16'h0000)
		begin
			lo = (kind == 0) ? x / y : {16'h0000, x[15:0]} / y;
			rm = (kind == 0) ? 16'(x % y) : x[15:0] % y;
		end
		for (int k = 0; k < len; k++)
		begin
			i = ord[23 - 4 * k -: 4];
			bus(1'b1, 5'(i * 4), (i < 4) ? x[8 * i +: 8] : y[8 * (i - 4) +: 8], rdq);
			if (k == 1)
			begin
				// Unrelated accesses in the middle of the order
				bus(1'b0, mdu_pkg::OFS_STATUS, 8'h00, rdq);
				bus(1'b0, 5'h1c, 8'h00, rdq);
				chk(rdq, mdu_pkg::UNMAPPED_RD, "unmapped read");
			end
		end
		#1;
		n = 0;
		while (busy === 1'b1 && n < 40)
		begin
			n++;
			@(posedge core_clk);
			#1;
		end
		chk(32'(n), (kind == 0) ? 32'd17 : (kind == 1) ? 32'd9 : 32'd11, "latency");
		bus(1'b0, mdu_pkg::OFS_STATUS, 8'h00, rdq);
		chk(32'(rdq[7:0]), {24'h0, 1'b0, ovf, 6'h00}, "status flags");
		for (int k = 0; k < len; k++)
		begin
			i = rord[23 - 4 * k -: 4];
			bus(1'b0, 5'(i * 4), 8'h00, rdq);
			chk(32'(rdq[7:0]), 32'((i < 4) ? lo[8 * i +: 8] : rm[8 * (i - 4) +: 8]),
				"result byte");
			if (k == 1)
				bus(1'b0, 5'h1c, 8'h00, rdq);
		end
	endtask

	// ==========================================================
	// Scenarios
	task automatic t_reset();
		bus(1'b0, mdu_pkg::OFS_STATUS, 8'h00, rdq);
		chk(32'(rdq[7:0]), 32'h0000_0000, "status after reset");
		bus(1'b1, 5'h1c, 8'h5a, rdq);
		bus(1'b0, 5'h1c, 8'h00, rdq);
		chk(rdq, mdu_pkg::UNMAPPED_RD, "unmapped write ignored");
		$display("test reset done");
	endtask

	task automatic t_div32();
		do_op(0, 32'hdead_beef, 16'h1234);
		do_op(0, 32'h1234_5678, 16'h0000);
		$display("test div32 done");
	endtask

	task automatic t_div16();
		do_op(1, 32'h0000_fffe, 16'h0007);
		do_op(1, 32'h0000_8001, 16'h0000);
		$display("test div16 done");
	endtask

	task automatic t_mul();
		do_op(2, 32'h0000_00ff, 16'h0101);
		do_op(2, 32'h0000_ffff, 16'hffff);
		$display("test mul done");
	endtask

	task automatic t_err();
		int n;
		bus(1'b1, mdu_pkg::OFS_BYTE0, 8'h02, rdq);
		bus(1'b1, mdu_pkg::OFS_BYTE4, 8'h03, rdq);
		bus(1'b1, mdu_pkg::OFS_BYTE1, 8'h00, rdq);
		bus(1'b1, mdu_pkg::OFS_BYTE5, 8'h00, rdq);
		// Write while busy must be dropped
		bus(1'b1, mdu_pkg::OFS_BYTE0, 8'haa, rdq);
		n = 0;
		while (busy === 1'b1 && n < 40)
		begin
			n++;
			@(posedge core_clk);
		end
		repeat (2) @(posedge core_clk);
		bus(1'b0, mdu_pkg::OFS_STATUS, 8'h00, rdq);
		chk(32'(rdq[7:0]), 32'h0000_0080, "error flag set");
		bus(1'b0, mdu_pkg::OFS_STATUS, 8'h00, rdq);
		chk(32'(rdq[7:0]), 32'h0000_0000, "error flag cleared");
		bus(1'b0, mdu_pkg::OFS_BYTE0, 8'h00, rdq);
		chk(32'(rdq[7:0]), 32'h0000_0006, "product kept");
		$display("test error flag done");
	endtask

	task automatic t_badorder();
		bus(1'b1, mdu_pkg::OFS_BYTE0, 8'h21, rdq);
		bus(1'b1, mdu_pkg::OFS_BYTE5, 8'h55, rdq);
		repeat (3)
		begin
			#1;
			chk({31'h0, busy}, 32'h0, "no start");
			@(posedge core_clk);
		end
		bus(1'b0, mdu_pkg::OFS_BYTE0, 8'h00, rdq);
		chk(32'(rdq[7:0]), 32'h0000_0021, "byte 0 written");
		bus(1'b0, mdu_pkg::OFS_BYTE1, 8'h00, rdq);
		chk(32'(rdq[7:0]), 32'h0000_0000, "byte 1 untouched");
		bus(1'b0, mdu_pkg::OFS_BYTE5, 8'h00, rdq);
		chk(32'(rdq[7:0]), 32'h0000_0055, "byte 5 written");
		$display("test bad order done");
	endtask

	// ==========================================================
	// Main sequence and watchdog
	initial
	begin
		repeat (5) @(posedge core_clk);
		rst <= 1'b0;
		t_reset();
		t_div32();
		t_div16();
		t_mul();
		t_err();
		t_badorder();
		give_verdict();
	end

	// Whole run needs well under a thousand cycles
	initial
	begin
		#(50 * 4000);
		mismatches++;
		give_verdict();
	end
endmodule // tb_top
